// file: pwp_params.svh
// Functional notes
// - Clear-view one-bit removes that protection
// - Set-view one-bit enables that protection
// - Both views read the same vector
// - Zero bits written leave protection unchanged
// - Protected write discarded, answered with error
// - Setting an already-set bit returns error
// - Clearing an already-clear bit returns error
// - Byte, halfword and word accesses all work
// - One vector at two addresses, clear 0x00
// - Bit 6 interrupt ctrl, bit 5 counter
// - Set view at 0x04, resets zero
`ifndef PWP_PARAMS_SVH
`define PWP_PARAMS_SVH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define PWP_AW 12
`define PWP_DW 32
`define PWP_NLANE 4
`define PWP_VEC_W 8

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PWP_OFS_CLR 12'h000
`define PWP_OFS_SET 12'h004
`define PWP_OFS_STATUS 12'h008
`define PWP_OFS_MASK 12'h00c

// ----------------------------------------
// Protect vector layout and reset
// ----------------------------------------
`define PWP_BIT_POWER_MANAGER 1
`define PWP_BIT_SYSTEM_CONTROL_UNIT 2
`define PWP_BIT_GENERIC_CLOCK_CTRL 3
`define PWP_BIT_WATCHDOG_TIMER 4
`define PWP_BIT_REAL_TIME_CNT 5
`define PWP_BIT_EXT_IRQ_CTRL 6
`define PWP_IMPL_MASK 8'h7e
`define PWP_PROT_RESET 8'h00

// ----------------------------------------
// Event status layout and reset
// ----------------------------------------
`define PWP_ST_W 3
`define PWP_ST_BLOCKED 0
`define PWP_ST_DBL_SET 1
`define PWP_ST_DBL_CLR 2
`define PWP_ST_RESET 3'h0
`define PWP_MASK_RESET 3'h0

`endif

// file: pwp_pkg.sv
`include "pwp_params.svh"

package pwp_pkg;
	// Request from the processor towards the guarded peripherals
	typedef struct packed {
		logic valid;
		logic write;
		logic [`PWP_VEC_W-1:0] target;
	} pwp_greq_s;

	// Answer of the gate: forwarded selects and error
	typedef struct packed {
		logic [`PWP_VEC_W-1:0] fwd;
		logic err;
	} pwp_gresp_s;
endpackage

// file: pwp_lane_merge.sv
`timescale 1ns/1ps

// One byte lane: write data pass only where the strobe is set
module pwp_lane_merge (
	input wire logic en,
	input wire logic strb,
	input wire logic [7:0] wdata,
	output logic [7:0] bits
);
	// Unstrobed lanes contribute no ones, so no other byte is touched
	assign bits = (en && strb) ? wdata : 8'h00;
endmodule

// file: pwp_gate.sv
`timescale 1ns/1ps

// One peripheral: forward its select unless a write hits protection
module pwp_gate (
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic target,
	input wire logic protect,
	output logic fwd,
	output logic blocked
);
	// Reads always pass; only writes are stopped
	assign blocked = req_valid && req_write && target && protect;
	assign fwd = req_valid && target && !blocked;
endmodule

// file: pwp_top.sv
`timescale 1ns/1ps
`include "pwp_params.svh"

module pwp_top
	import pwp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PWP_AW-1:0] paddr,
	input wire logic [`PWP_DW-1:0] pwdata,
	input wire logic [`PWP_NLANE-1:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [`PWP_DW-1:0] prdata,
	input wire pwp_greq_s greq,
	output pwp_gresp_s gresp,
	output logic irq
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [`PWP_VEC_W-1:0] protect; // Protect vector, one bit a peripheral
	logic [`PWP_VEC_W-1:0] next_protect;
	logic [`PWP_ST_W-1:0] status; // Sticky event flags
	logic [`PWP_ST_W-1:0] next_status;
	logic [`PWP_ST_W-1:0] mask; // Interrupt enables, same layout
	logic [`PWP_ST_W-1:0] next_mask;
	logic [`PWP_DW-1:0] next_prdata;
	logic setup; // First cycle of an APB transfer
	logic access; // Completing cycle of an APB transfer
	logic [`PWP_AW-1:0] waddr; // Word-aligned address
	logic hit_clr;
	logic hit_set;
	logic hit_status;
	logic hit_mask;
	logic hit_any;
	logic wr_clr; // Completing write to the clear view
	logic wr_set; // Completing write to the set view
	logic [`PWP_DW-1:0] strobed; // Write data with unstrobed lanes zeroed
	logic [`PWP_VEC_W-1:0] clr_bits;
	logic [`PWP_VEC_W-1:0] set_bits;
	logic dbl_set; // Set of an already protected bit
	logic dbl_clr; // Clear of an already unprotected bit
	logic [`PWP_VEC_W-1:0] blocked; // Per-peripheral blocked write
	logic [`PWP_ST_W-1:0] events;
	logic [`PWP_ST_W-1:0] rd_clear; // Status bits handed to software

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	// Low address bits are ignored; pstrb alone selects the lanes and the size
	assign waddr = {paddr[`PWP_AW-1:2], 2'b00};
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign hit_clr = (waddr == `PWP_OFS_CLR);
	assign hit_set = (waddr == `PWP_OFS_SET);
	assign hit_status = (waddr == `PWP_OFS_STATUS);
	assign hit_mask = (waddr == `PWP_OFS_MASK);
	assign hit_any = hit_clr || hit_set || hit_status || hit_mask;
	assign wr_clr = access && pwrite && hit_clr;
	assign wr_set = access && pwrite && hit_set;

	// ----------------------------------------
	// Byte lane merge
	// ----------------------------------------
	// Each lane is qualified by its own strobe, so 8, 16 and 32 bit
	// writes are all direct and atomic
	genvar gl;
	generate
		for (gl = 0; gl < `PWP_NLANE; gl = gl + 1) begin : g_lane
			pwp_lane_merge u_lane (
				.en(access && pwrite),
				.strb(pstrb[gl]),
				.wdata(pwdata[gl*8 +: 8]),
				.bits(strobed[gl*8 +: 8])
			);
		end
	endgenerate

	// Only assigned bits ever take a one; the rest stay zero
	assign clr_bits = wr_clr ? (strobed[`PWP_VEC_W-1:0] & `PWP_IMPL_MASK)
		: `PWP_PROT_RESET;
	assign set_bits = wr_set ? (strobed[`PWP_VEC_W-1:0] & `PWP_IMPL_MASK)
		: `PWP_PROT_RESET;

	// ----------------------------------------
	// Double protect and unprotect checks
	// ----------------------------------------
	// A bad bit in the write still lets the other bits take effect
	assign dbl_set = |(set_bits & protect);
	assign dbl_clr = |(clr_bits & ~protect);

	// ----------------------------------------
	// Peripheral write gates
	// ----------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < `PWP_VEC_W; gp = gp + 1) begin : g_gate
			pwp_gate u_gate (
				.req_valid(greq.valid),
				.req_write(greq.write),
				.target(greq.target[gp]),
				.protect(protect[gp]),
				.fwd(gresp.fwd[gp]),
				.blocked(blocked[gp])
			);
		end
	endgenerate

	// Error goes straight back so the processor takes its exception
	assign gresp.err = |blocked;

	// ----------------------------------------
	// Protect vector next state
	// ----------------------------------------
	// Zero bits in either view leave the vector alone, so software
	// never needs a read-modify-write
	always_comb begin
		next_protect = (protect & ~clr_bits) | set_bits;
	end

	// Reset leaves every peripheral unprotected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			protect <= `PWP_PROT_RESET;
		end else begin
			protect <= next_protect;
		end
	end

	// ----------------------------------------
	// Event status and interrupt mask
	// ----------------------------------------
	assign events[`PWP_ST_BLOCKED] = |blocked;
	assign events[`PWP_ST_DBL_SET] = dbl_set;
	assign events[`PWP_ST_DBL_CLR] = dbl_clr;

	// Only bits already captured in prdata are cleared by the read, so
	// an event landing during the transfer is kept for the next read
	assign rd_clear = (access && !pwrite && hit_status)
		? prdata[`PWP_ST_W-1:0] : `PWP_ST_RESET;

	always_comb begin
		// Set wins over the read clear
		next_status = (status & ~rd_clear) | events;
		next_mask = mask;
		if (access && pwrite && hit_mask) begin
			next_mask = strobed[`PWP_ST_W-1:0];
			if (!pstrb[0]) begin
				// Mask lives in lane 0; other lanes do not touch it
				next_mask = mask;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= `PWP_ST_RESET;
			mask <= `PWP_MASK_RESET;
		end else begin
			status <= next_status;
			mask <= next_mask;
		end
	end

	// Level interrupt while any enabled flag stands
	assign irq = |(status & mask);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Read data is captured in the setup cycle so it comes from a
	// flop, yet the transfer still needs no wait state
	always_comb begin
		next_prdata = prdata;
		if (setup) begin
			next_prdata = '0;
			if (hit_clr || hit_set) begin
				next_prdata[`PWP_VEC_W-1:0] = protect;
			end else if (hit_status) begin
				next_prdata[`PWP_ST_W-1:0] = status;
			end else if (hit_mask) begin
				next_prdata[`PWP_ST_W-1:0] = mask;
			end else begin
				// Unmapped reads return zero with an error
				next_prdata = '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else begin
			prdata <= next_prdata;
		end
	end

	// ----------------------------------------
	// Transfer answer
	// ----------------------------------------
	// Every access completes in its first access cycle
	assign pready = 1'b1;

	// Error on unmapped address or on a double protect or unprotect
	assign pslverr = access && (!hit_any || dbl_set || dbl_clr);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Ones written to the clear view leave those bits low
	property p_clr_effect;
		wr_clr |=> ((protect & $past(clr_bits)) == `PWP_PROT_RESET);
	endproperty
	a_clr_effect: assert property (p_clr_effect)
		else $error("clear view write did not unprotect");

	// Ones written to the set view leave those bits high
	property p_set_effect;
		wr_set |=> ((protect & $past(set_bits)) == $past(set_bits));
	endproperty
	a_set_effect: assert property (p_set_effect)
		else $error("set view write did not protect");

	// Both views read identically to the vector at setup
	property p_views_equal;
		setup && !pwrite && (hit_clr || hit_set)
			|=> (prdata[`PWP_VEC_W-1:0] == $past(protect))
			&& (prdata[`PWP_DW-1:`PWP_VEC_W] == '0);
	endproperty
	a_views_equal: assert property (p_views_equal)
		else $error("protect view read mismatch");

	// A set write changes no bit written as zero
	property p_zero_keep;
		wr_set |=> (protect == ($past(protect) | $past(set_bits)));
	endproperty
	a_zero_keep: assert property (p_zero_keep)
		else $error("zero bit changed protect vector");

	// A write to a protected peripheral is errored and not forwarded
	property p_block;
		greq.valid && greq.write && |(greq.target & protect)
			|-> gresp.err && ((gresp.fwd & protect) == '0);
	endproperty
	a_block: assert property (p_block)
		else $error("protected write was not blocked");

	// Double protect errors and is flagged one cycle later
	property p_dbl_set;
		wr_set && |(set_bits & protect)
			|-> pslverr ##1 status[`PWP_ST_DBL_SET];
	endproperty
	a_dbl_set: assert property (p_dbl_set)
		else $error("double protect not reported");

	// Double unprotect errors and is flagged one cycle later
	property p_dbl_clr;
		wr_clr && |(clr_bits & ~protect)
			|-> pslverr ##1 status[`PWP_ST_DBL_CLR];
	endproperty
	a_dbl_clr: assert property (p_dbl_clr)
		else $error("double unprotect not reported");

	// A write with lane 0 unstrobed leaves the vector as it was
	property p_lane;
		access && pwrite && (hit_set || hit_clr) && !pstrb[0]
			|=> $stable(protect);
	endproperty
	a_lane: assert property (p_lane)
		else $error("unstrobed lane changed protect vector");

	// Unassigned bits never rise
	property p_unassigned;
		(protect & ~`PWP_IMPL_MASK) == '0;
	endproperty
	a_unassigned: assert property (p_unassigned)
		else $error("unassigned protect bit set");

	// Clean writes to either view are never errored
	property p_no_err;
		(wr_set || wr_clr) && !dbl_set && !dbl_clr |-> !pslverr;
	endproperty
	a_no_err: assert property (p_no_err)
		else $error("clean protect write answered with error");

	// A clear write changes no bit written as zero
	property p_clr_keep;
		wr_clr |=> (protect == ($past(protect) & ~$past(clr_bits)));
	endproperty
	a_clr_keep: assert property (p_clr_keep)
		else $error("zero bit changed on clear write");

	// Unmapped places error and read as zero
	property p_unmapped;
		access && !hit_any |-> pslverr && (prdata == '0);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not errored");

	// A blocked write is flagged in status one cycle later
	property p_blocked_flag;
		greq.valid && greq.write && |(greq.target & protect)
			|=> status[`PWP_ST_BLOCKED];
	endproperty
	a_blocked_flag: assert property (p_blocked_flag)
		else $error("blocked write not flagged");

	// Accesses that hit no protection pass unchanged and unerrored
	property p_pass;
		greq.valid && !(greq.write && |(greq.target & protect))
			|-> (gresp.fwd == greq.target) && !gresp.err;
	endproperty
	a_pass: assert property (p_pass)
		else $error("unprotected access held back");

	// Reading either view never alters the vector
	property p_read_keep;
		access && !pwrite |=> (protect == $past(protect));
	endproperty
	a_read_keep: assert property (p_read_keep)
		else $error("read changed protect vector");

	// A status read clears what it returned unless a new event lands
	property p_status_clear;
		access && !pwrite && hit_status && !(|events)
			|=> ((status & $past(rd_clear)) == '0);
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("status read did not clear flags");

	// Main scenarios
	c_blocked: cover property (gresp.err ##1 irq);
	c_dbl_set: cover property (wr_set && dbl_set);
	c_dbl_clr: cover property (wr_clr && dbl_clr);
	c_protect_cycle: cover property (wr_set ##[1:20] wr_clr);
	c_status_read: cover property (access && !pwrite && hit_status
		&& |prdata[`PWP_ST_W-1:0]);

endmodule

// file: pwp_periph_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Guarded peripherals: one data byte each
// ----------------------------------------
module pwp_periph_model
	import pwp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire pwp_greq_s greq,
	input wire pwp_gresp_s gresp,
	input wire logic [7:0] wdata,
	output logic [63:0] mem
);
	// Only a forwarded select lands; a held-back write leaves no trace
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem <= '0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (greq.valid && greq.write && gresp.fwd[i]) begin
					mem[i*8 +: 8] <= wdata;
				end
			end
		end
	end
endmodule

// file: tb_pwp_top.sv
`timescale 1ns/1ps
`include "pwp_params.svh"

// ----------------------------------------
// Bench for the write-protect controller
// ----------------------------------------
module tb_pwp_top
	import pwp_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [`PWP_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0, rd;
	logic [3:0] pstrb = '0;
	logic pready, pslverr, irq, er;
	logic [31:0] prdata;
	pwp_greq_s greq = '0;
	pwp_gresp_s gresp;
	logic [7:0] gwdata = '0, prot = '0; // Expected protect vector
	logic [63:0] mem, exp_mem = '0;
	int fails = 0, cmp_count = 0, cyc = 0;

	pwp_top i_pwp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.greq(greq), .gresp(gresp), .irq(irq));
	pwp_periph_model i_pwp_periph_model (.pclk(pclk), .presetn(presetn),
		.greq(greq), .gresp(gresp), .wdata(gwdata), .mem(mem));

	always #12.5 pclk = ~pclk;

	// Hang guard: the whole run needs well under this many cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the wait on pready ends once pready is high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// Protect bits a write offers: lane 0 only, assigned bits only
	function automatic logic [7:0] offered(input logic [31:0] d,
		input logic [3:0] s);
		return s[0] ? (d[7:0] & `PWP_IMPL_MASK) : 8'h00;
	endfunction

	// Write one view, then read both views back
	task automatic op(input logic sv, input logic [31:0] d,
		input logic [3:0] s);
		logic [7:0] b;
		logic e;
		b = offered(d, s);
		e = sv ? |(b & prot) : |(b & ~prot);
		apb(1, sv ? `PWP_OFS_SET : `PWP_OFS_CLR, d, s);
		check({31'h0, er}, {31'h0, e});
		prot = sv ? prot | b : prot & ~b;
		apb(0, `PWP_OFS_CLR, 0, 0);
		check(rd, {24'h0, prot});
		check({31'h0, er}, 32'h0);
		apb(0, `PWP_OFS_SET, 0, 0);
		check(rd, {24'h0, prot});
	endtask

	// Processor write towards one guarded peripheral
	task automatic gw(input logic [7:0] t, input logic [7:0] d);
		greq <= '{valid: 1'b1, write: 1'b1, target: t};
		gwdata <= d;
		@(negedge pclk);
		check({23'h0, gresp}, {23'h0, t & ~prot, |(t & prot)});
		if (!(|(t & prot))) exp_mem[$clog2(t)*8 +: 8] = d;
		@(posedge pclk);
		greq <= '0;
		@(negedge pclk);
		check(mem[31:0], exp_mem[31:0]);
		check(mem[63:32], exp_mem[63:32]);
	endtask

	task automatic wrap_up();
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [3:0] strbs [4];
		strbs = '{4'h1, 4'h3, 4'hf, 4'h2};
		void'($urandom(31));
		repeat (8) @(posedge pclk);
		presetn <= 1;
		// Reset state of all four registers
		for (int a = 0; a < 16; a += 4) begin
			apb(0, a[11:0], 0, 0);
			check(rd, 32'h0);
		end
		// Corners: double protect, double unprotect, lane and junk bits
		op(1, 32'h40, 4'h1);
		op(1, 32'h40, 4'h1);
		op(0, 32'h20, 4'h1);
		op(1, 32'hffffffff, 4'he);
		op(1, 32'h81, 4'h1);
		op(0, 32'h7e, 4'h3);
		for (int k = 0; k < 24; k++) begin
			op(1'($urandom_range(1)), $urandom, strbs[$urandom_range(3)]);
		end
		// Unmapped place: error, reads zero
		apb(1, 12'h010, 32'hffffffff, 4'hf);
		check({31'h0, er}, 32'h1);
		apb(0, 12'h010, 0, 0);
		check(rd, 32'h0);
		check({31'h0, er}, 32'h1);
		// Current state is read from the set view before changing it
		apb(0, `PWP_OFS_SET, 0, 0);
		check(rd, {24'h0, prot});
		op(1, ~prot & 8'h40, 4'h1);
		op(0, prot & 8'h20, 4'h1);
		apb(0, `PWP_OFS_STATUS, 0, 0);
		// Blocked write while masked: status set, no interrupt
		gw(8'h40, 8'(($urandom)));
		check({31'h0, irq}, 32'h0);
		apb(1, `PWP_OFS_MASK, 32'h1, 4'hf);
		@(negedge pclk);
		check({31'h0, irq}, 32'h1);
		gw(8'h20, 8'h5a);
		apb(0, `PWP_OFS_STATUS, 0, 0);
		check(rd, 32'h1);
		@(negedge pclk);
		check({31'h0, irq}, 32'h0);
		wrap_up();
	end
endmodule
